//--- src/irs_pkg.sv
// shared constants and types for the two-wire register access slave
package irs_pkg;

  // fixed 7-bit slave address, 1101000
  localparam logic [6:0] IRS_SLAVE_ADDR = 7'h68;
  localparam int         IRS_DATA_W     = 8;
  localparam logic [3:0] IRS_BYTE_BITS  = 4'h8;
  localparam logic [3:0] IRS_CNT_RST    = 4'h0;
  localparam logic [7:0] IRS_PTR_RST    = 8'h00;
  localparam logic [7:0] IRS_PTR_STEP   = 8'h01;
  // direction bit values in the address byte
  localparam logic       IRS_DIR_WRITE  = 1'b0;
  localparam logic       IRS_DIR_READ   = 1'b1;
  // serial clock limits the port is sized for (fast and standard mode)
  localparam int         IRS_CLK_HZ     = 25000000;
  localparam int         IRS_FAST_HZ    = 400000;
  localparam int         IRS_STD_HZ     = 100000;
  // system clocks per fastest serial clock period, rounded down
  localparam int         IRS_SCL_CYC    = IRS_CLK_HZ / IRS_FAST_HZ;

  typedef enum logic [2:0] {
    IRS_IDLE,
    IRS_ADDR,
    IRS_ADDR_ACK,
    IRS_RX,
    IRS_RX_ACK,
    IRS_TX,
    IRS_TX_ACK,
    IRS_IGNORE
  } irs_state_t;

  // one register write toward the user register file
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } irs_wr_t;

  // bus events derived from the sampled pins
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } irs_evt_t;

endpackage

//--- src/irs_sync.sv
// two-flop synchroniser for pin inputs, one lane per bit
`timescale 1ns/1ps
module irs_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_lane
      logic meta_q;
      logic sync_q;
      // idle bus is high, so both stages reset high
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end else if (ce) begin
          meta_q <= async_i[g];
          sync_q <= meta_q;
        end
      end
      assign sync_o[g] = sync_q;
    end
  endgenerate

endmodule

//--- src/irs_cond.sv
// edge and START/STOP detector on the synchronised bus lines
`timescale 1ns/1ps
module irs_cond (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            ce,
  input  wire logic            scl_s,
  input  wire logic            sda_s,
  output irs_pkg::irs_evt_t    evt
);

  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  always_comb begin
    evt.scl_rise = scl_s & ~scl_q;
    evt.scl_fall = ~scl_s & scl_q;
    // bus conditions
    // data moving while clock stays high is a condition, not data
    evt.start    = scl_s & scl_q & sda_q & ~sda_s;
    evt.stop     = scl_s & scl_q & ~sda_q & sda_s;
  end

endmodule

//--- src/irs_slave.sv
// two-wire slave port giving an external master byte access to registers
`timescale 1ns/1ps
module irs_slave (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  output logic [7:0]            reg_addr,
  input  wire logic [7:0]       rd_data,
  output irs_pkg::irs_wr_t      wr,
  output logic                  busy
);

  logic [1:0]          pins_s;
  logic                scl_s;
  logic                sda_s;
  irs_pkg::irs_evt_t   evt;
  irs_pkg::irs_state_t state_q;
  logic [3:0]          cnt_q;
  logic [7:0]          rx_q;
  logic [7:0]          tx_q;
  logic [7:0]          ptr_q;
  logic                dir_q;
  logic                first_q;
  logic                nack_q;
  logic                oe_q;
  irs_pkg::irs_wr_t    wr_q;
  logic                done;
  logic                hit;
  logic                rise;
  logic                fall;

  // sampling rate
  // 25 MHz gives about 60 samples per fast-mode clock, ample margin
  irs_sync #(
    .W (2)
  ) u_sync (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .async_i ({scl_i, sda_i}),
    .sync_o  (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  irs_cond u_cond (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .scl_s (scl_s),
    .sda_s (sda_s),
    .evt   (evt)
  );

  assign rise = evt.scl_rise;
  assign fall = evt.scl_fall;
  assign done = (cnt_q == irs_pkg::IRS_BYTE_BITS);
  assign hit  = (rx_q[7:1] == irs_pkg::IRS_SLAVE_ADDR);

  // open drain: only ever pull low
  assign sda_o    = 1'b0;
  assign sda_oe   = oe_q;
  assign reg_addr = ptr_q;
  assign wr       = wr_q;
  assign busy     = (state_q != irs_pkg::IRS_IDLE) && (state_q != irs_pkg::IRS_IGNORE);

  // transfer sequencing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= irs_pkg::IRS_IDLE;
      cnt_q   <= irs_pkg::IRS_CNT_RST;
      dir_q   <= irs_pkg::IRS_DIR_WRITE;
      first_q <= 1'b0;
      nack_q  <= 1'b0;
    end else if (ce) begin
      if (evt.start) begin
        state_q <= irs_pkg::IRS_ADDR;
        cnt_q   <= irs_pkg::IRS_CNT_RST;
      end else if (evt.stop) begin
        state_q <= irs_pkg::IRS_IDLE;
        cnt_q   <= irs_pkg::IRS_CNT_RST;
      end else begin
        unique case (state_q)
          irs_pkg::IRS_IDLE, irs_pkg::IRS_IGNORE: begin
          end
          irs_pkg::IRS_ADDR: begin
            if (rise && !done) begin
              cnt_q <= cnt_q + 4'h1;
            end
            if (fall && done) begin
              state_q <= hit ? irs_pkg::IRS_ADDR_ACK : irs_pkg::IRS_IGNORE;
              dir_q   <= rx_q[0];
            end
          end
          irs_pkg::IRS_ADDR_ACK: begin
            if (fall) begin
              state_q <= (dir_q == irs_pkg::IRS_DIR_READ) ? irs_pkg::IRS_TX
                                                          : irs_pkg::IRS_RX;
              cnt_q   <= irs_pkg::IRS_CNT_RST;
              first_q <= 1'b1;
            end
          end
          irs_pkg::IRS_RX, irs_pkg::IRS_TX: begin
            if (rise && !done) begin
              cnt_q <= cnt_q + 4'h1;
            end
            if (fall && done) begin
              state_q <= (state_q == irs_pkg::IRS_RX) ? irs_pkg::IRS_RX_ACK
                                                      : irs_pkg::IRS_TX_ACK;
            end
          end
          irs_pkg::IRS_RX_ACK: begin
            if (fall) begin
              state_q <= irs_pkg::IRS_RX;
              cnt_q   <= irs_pkg::IRS_CNT_RST;
              first_q <= 1'b0;
            end
          end
          irs_pkg::IRS_TX_ACK: begin
            if (rise) begin
              nack_q <= sda_s;
            end
            if (fall) begin
              state_q <= nack_q ? irs_pkg::IRS_IGNORE : irs_pkg::IRS_TX;
              cnt_q   <= irs_pkg::IRS_CNT_RST;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_q <= 8'h00;
    end else if (ce && rise && !done &&
                 (state_q == irs_pkg::IRS_ADDR || state_q == irs_pkg::IRS_RX)) begin
      rx_q <= {rx_q[6:0], sda_s};
    end
  end

  // outgoing byte; rd_data is sampled the cycle the byte is loaded
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_q <= 8'h00;
    end else if (ce && fall && !evt.start && !evt.stop) begin
      if ((state_q == irs_pkg::IRS_ADDR_ACK && dir_q == irs_pkg::IRS_DIR_READ) ||
          (state_q == irs_pkg::IRS_TX_ACK && !nack_q)) begin
        tx_q <= rd_data;
      end else if (state_q == irs_pkg::IRS_TX && !done) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // data line drive, changed just after the clock falls, or released at a start or stop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_q <= 1'b0;
    end else if (ce) begin
      if (evt.start || evt.stop) begin
        oe_q <= 1'b0;
      end else if (fall) begin
        unique case (state_q)
          irs_pkg::IRS_ADDR:     if (done) oe_q <= hit;
          irs_pkg::IRS_ADDR_ACK: oe_q <= (dir_q == irs_pkg::IRS_DIR_READ) & ~rd_data[7];
          irs_pkg::IRS_RX:       if (done) oe_q <= 1'b1;
          irs_pkg::IRS_RX_ACK:   oe_q <= 1'b0;
          // release for the master's answer after the eighth bit
          irs_pkg::IRS_TX:       oe_q <= done ? 1'b0 : ~tx_q[6];
          irs_pkg::IRS_TX_ACK:   oe_q <= ~nack_q & ~rd_data[7];
          irs_pkg::IRS_IDLE, irs_pkg::IRS_IGNORE: oe_q <= 1'b0;
        endcase
      end
    end
  end

  // register pointer; only reset clears it, transfers never do
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_q <= irs_pkg::IRS_PTR_RST;
    end else if (ce && !evt.start && !evt.stop) begin
      if (state_q == irs_pkg::IRS_RX && fall && done && first_q) begin
        ptr_q <= rx_q;
      end else if (state_q == irs_pkg::IRS_RX && fall && done) begin
        ptr_q <= ptr_q + irs_pkg::IRS_PTR_STEP;
      // read step, after each byte the master clocked out
      end else if (state_q == irs_pkg::IRS_TX_ACK && rise) begin
        ptr_q <= ptr_q + irs_pkg::IRS_PTR_STEP;
      end
    end
  end

  // one-cycle write strobe toward the register file
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
    end else if (ce) begin
      wr_q.en <= !evt.start && !evt.stop && state_q == irs_pkg::IRS_RX &&
                 fall && done && !first_q;
      if (state_q == irs_pkg::IRS_RX && fall && done) begin
        wr_q.addr <= ptr_q;
        wr_q.data <= rx_q;
      end
    end
  end

  // checks; an attempt is dropped whenever the clock enable is low
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  addr_no_match_a: assert property (
    state_q == irs_pkg::IRS_ADDR && fall && done && !hit && !evt.start && !evt.stop
    |=> state_q == irs_pkg::IRS_IGNORE && !sda_oe ##1 !sda_oe)
    else $error("mismatched address was not ignored");

  addr_ack_drive_a: assert property (
    state_q == irs_pkg::IRS_ADDR && fall && done && hit && !evt.start && !evt.stop
    |=> sda_oe && state_q == irs_pkg::IRS_ADDR_ACK)
    else $error("matching address not acknowledged");

  write_ack_a: assert property (
    wr.en |-> sda_oe && state_q == irs_pkg::IRS_RX_ACK)
    else $error("written byte not acknowledged");

  ptr_load_a: assert property (
    state_q == irs_pkg::IRS_RX && first_q && fall && done && !evt.start && !evt.stop
    |=> ptr_q == $past(rx_q) && !wr.en)
    else $error("first write byte did not load pointer");

  ptr_step_a: assert property (
    wr.en |-> ptr_q == wr.addr + irs_pkg::IRS_PTR_STEP)
    else $error("pointer did not step after write");

  ptr_keep_a: assert property (
    evt.start || evt.stop |=> $stable(ptr_q))
    else $error("pointer changed at a bus condition");

  read_first_a: assert property (
    state_q == irs_pkg::IRS_ADDR_ACK && dir_q && fall && !evt.start && !evt.stop
    |=> tx_q == $past(rd_data) && sda_oe == !$past(rd_data[7]))
    else $error("read did not start at pointer");

  msb_first_a: assert property (
    state_q == irs_pkg::IRS_TX && fall && !done && !evt.start && !evt.stop
    |=> sda_oe == !$past(tx_q[6]))
    else $error("transmit bit order wrong");

  nack_release_a: assert property (
    state_q == irs_pkg::IRS_TX_ACK && nack_q && fall && !evt.start && !evt.stop
    |=> !sda_oe [*2])
    else $error("data line held after refusal");

  start_restart_a: assert property (
    evt.start |=> state_q == irs_pkg::IRS_ADDR && cnt_q == irs_pkg::IRS_CNT_RST)
    else $error("start did not restart address match");

  drive_scl_low_a: assert property (
    $changed(sda_oe) && !$past(evt.start) && !$past(evt.stop) |-> !scl_s)
    else $error("data drive changed with clock high");

  write_cover_c: cover property (wr.en);
  read_cover_c: cover property (state_q == irs_pkg::IRS_TX_ACK && rise && !sda_s);
  nack_cover_c: cover property (state_q == irs_pkg::IRS_TX_ACK && nack_q && fall);
  rstart_cover_c: cover property (evt.start && state_q == irs_pkg::IRS_RX);

endmodule

//--- verif/irs_master.sv
// behavioural two-wire bus master driving the slave pins
`timescale 1ns/1ps
module irs_master (
  input  wire logic clk,
  input  wire logic sda_o,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic sda_m;

  assign sda = sda_m & ~(sda_oe & ~sda_o);

  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // start or repeated start, clock high
  task automatic start();
    tick(1);
    sda_m = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask

  // stop leaves bus idle, clock stands high
  task automatic stop();
    tick(1);
    sda_m = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b1;
    tick(4);
  endtask

  // data moves only while clock low
  task automatic bit_io(input logic b, output logic s);
    tick(1);
    sda_m = b;
    tick(3);
    scl = 1'b1;
    tick(4);
    s = sda;
    scl = 1'b0;
  endtask

  // msb first, ninth bit left to the slave
  task automatic wbyte(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, ack_n);
  endtask

  // acknowledge all but the last byte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule

//--- verif/irs_slave_tb.sv
// self-checking bench for the two-wire register access slave
`timescale 1ns/1ps
module irs_slave_tb;
  localparam logic [7:0] AW = {irs_pkg::IRS_SLAVE_ADDR, irs_pkg::IRS_DIR_WRITE};
  localparam logic [7:0] AR = {irs_pkg::IRS_SLAVE_ADDR, irs_pkg::IRS_DIR_READ};
  logic             clk;
  logic             rst;
  logic             ce;
  logic             scl;
  logic             sda;
  logic             sda_o;
  logic             sda_oe;
  logic [7:0]       reg_addr;
  logic [7:0]       rd_data;
  irs_pkg::irs_wr_t wr;
  logic             busy;
  logic [7:0]       regs [256];
  logic             a;
  logic [7:0]       d;
  int               mismatches;
  int               checks;
  int               wr_cnt;
  int               cyc;

  irs_slave uut (.clk(clk), .rst(rst), .ce(ce), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .reg_addr(reg_addr), .rd_data(rd_data), .wr(wr), .busy(busy));
  irs_master m (.clk(clk), .sda_o(sda_o), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  // user register file behind the port
  assign rd_data = regs[reg_addr];

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'(i) ^ 8'hC3;
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr.en === 1'b1) begin
      regs[wr.addr] <= wr.data;
      wr_cnt <= wr_cnt + 1;
    end
    if (cyc == 20000) begin
      mismatches++;
      $display("ERROR %0t timeout", $time);
      results();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic t_write();
    m.start();
    m.wbyte(AW, a);
    chk(a, 8'h00);
    m.wbyte(8'h10, a);
    chk(a, 8'h00);
    m.wbyte(8'hA5, a);
    chk(a, 8'h00);
    m.wbyte(8'h3C, a);
    chk(a, 8'h00);
    m.stop();
    chk(regs[8'h10], 8'hA5);
    chk(regs[8'h11], 8'h3C);
    chk(8'(wr_cnt), 8'h02);
    chk(reg_addr, 8'h12);
    chk(busy, 8'h00);
    $display("test write done");
  endtask

  task automatic t_wrap();
    m.start();
    m.wbyte(AW, a);
    m.wbyte(8'hFF, a);
    m.wbyte(8'h01, a);
    m.wbyte(8'h80, a);
    m.stop();
    chk(regs[8'hFF], 8'h01);
    chk(regs[8'h00], 8'h80);
    $display("test wrap done");
  endtask

  task automatic t_ptr_read();
    m.start();
    m.wbyte(AW, a);
    m.wbyte(8'h10, a);
    m.start();
    m.wbyte(AR, a);
    chk(a, 8'h00);
    m.rbyte(1'b0, d);
    chk(d, 8'hA5);
    m.rbyte(1'b1, d);
    chk(d, 8'h3C);
    m.tick(8);
    chk(sda_oe, 8'h00);
    m.stop();
    chk(reg_addr, 8'h12);
    $display("test pointer read done");
  endtask

  task automatic t_cur_read();
    m.start();
    m.wbyte(AR, a);
    chk(a, 8'h00);
    m.rbyte(1'b1, d);
    chk(d, 8'h12 ^ 8'hC3);
    m.stop();
    $display("test current read done");
  endtask

  task automatic t_bad_addr();
    m.start();
    m.wbyte(AW ^ 8'h02, a);
    chk(a, 8'h01);
    m.wbyte(8'h20, a);
    chk(a, 8'h01);
    m.wbyte(8'h55, a);
    chk(busy, 8'h00);
    m.start();
    m.wbyte(AW, a);
    chk(a, 8'h00);
    m.wbyte(8'h30, a);
    m.stop();
    chk(8'(wr_cnt), 8'h04);
    chk(reg_addr, 8'h30);
    $display("test bad address done");
  endtask

  // freeze mid-write while the ack stands, then finish the transfer
  task automatic t_freeze();
    m.start();
    m.wbyte(AW, a);
    m.wbyte(8'h40, a);
    ce = 1'b0;
    m.tick(20);
    chk(sda_oe, 8'h01);
    chk(reg_addr, 8'h40);
    chk(busy, 8'h01);
    ce = 1'b1;
    m.wbyte(8'h77, a);
    chk(a, 8'h00);
    m.stop();
    chk(regs[8'h40], 8'h77);
    chk(reg_addr, 8'h41);
    $display("test freeze done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    rst        = 1'b1;
    ce         = 1'b1;
    mismatches = 0;
    checks     = 0;
    wr_cnt     = 0;
    cyc        = 0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    m.tick(4);
    chk(reg_addr, irs_pkg::IRS_PTR_RST);
    t_write();
    t_wrap();
    t_ptr_read();
    t_cur_read();
    t_bad_addr();
    t_freeze();
    results();
  end
endmodule
